// file: core/adc_seq_pkg.sv
// Shared constants, types and layouts of the converter sequencer
package adc_seq_pkg;

  // Register addresses on the special-function register bus
  localparam logic [7:0] ADDR_CONTROL     = 8'h93;
  localparam logic [7:0] ADDR_RESULT_LOW  = 8'h94;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h95;

  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h80;
  localparam logic [9:0] RESULT_RESET  = 10'h000;
  localparam logic [1:0] HIGH_RESET    = 2'h0;
  localparam logic [7:0] READ_ZERO     = 8'h00;

  // Timing: converter clocks per conversion, main clocks per divider step
  localparam int         CONV_TICKS = 11;
  localparam logic [3:0] CONV_LAST  = 4'(CONV_TICKS - 1);
  localparam int         DIV_STEP   = 16;

  // Conversion modes
  typedef enum logic [1:0] {
    MODE_SINGLE     = 2'h0,
    MODE_CONTINUOUS = 2'h1,
    MODE_STOPPING   = 2'h2,
    MODE_RESET_GEN  = 2'h3
  } conv_mode_t;

  // Input selections
  typedef enum logic [1:0] {
    CHAN_INPUT_ZERO   = 2'h0,
    CHAN_INPUT_ONE    = 2'h1,
    CHAN_SIGNAL_IF    = 2'h2,
    CHAN_ZERO_EXT_REF = 2'h3
  } channel_t;

  // Layout of the control register, bit 7 first
  typedef struct packed {
    logic       converter_powerdown;
    logic       reserved;
    conv_mode_t conversion_mode_select;
    logic       reference_select;
    logic       conversion_run;
    channel_t   input_channel_select;
  } control_t;

  // Register bus request from the processor core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_req_t;

  // Controls toward the analog converter
  typedef struct packed {
    logic     powerdown;
    logic     internal_ref;
    logic     external_ref;
    channel_t channel;
    logic     sample_start;
    logic     clk_en;
  } analog_ctl_t;

endpackage : adc_seq_pkg

// file: core/adc_clock_divider.sv
// Converter clock enable from the main clock or the 32 kHz clock
`timescale 1ns/1ps
module adc_clock_divider
  import adc_seq_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // Control
  input  wire logic       enable,
  input  wire logic [5:0] div_sel,
  input  wire logic       slow_mode,
  input  wire logic       slow_clk,
  // Converter clock enable
  output logic            tick_q
);

  // Division ratio is sixteen per step, one step more than the field
  function automatic logic [10:0] div_limit(input logic [5:0] sel);
    div_limit = 11'(DIV_STEP) * (11'(sel) + 11'h001);
  endfunction : div_limit

  logic [9:0]  cnt_q;
  logic        slow_prev_q;
  logic [10:0] limit;
  logic        fast_wrap;
  logic        slow_rise;

  assign limit     = div_limit(div_sel);
  assign fast_wrap = ({1'b0, cnt_q} >= (limit - 11'h001));
  assign slow_rise = slow_clk & ~slow_prev_q;

  // Counter restarts whenever the converter is powered down, so ticks stay phase-free
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q       <= 10'h000;
      slow_prev_q <= 1'b0;
      tick_q      <= 1'b0;
    end else begin
      slow_prev_q <= slow_clk;
      cnt_q       <= (!enable || fast_wrap) ? 10'h000 : cnt_q + 10'h001;
      tick_q      <= enable & (slow_mode ? slow_rise : fast_wrap);
    end
  end

endmodule : adc_clock_divider

// file: core/adc_conversion_timer.sv
// Counts converter clocks through each conversion
`timescale 1ns/1ps
module adc_conversion_timer
  import adc_seq_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // Control
  input  wire logic tick,
  input  wire logic start,
  input  wire logic repeat_conv,
  input  wire logic abort,
  // Status
  output logic      busy_q,
  output logic      sample_q,
  output logic      done_q
);

  logic [3:0] cnt_q;
  logic       last_tick;

  assign last_tick = busy_q & tick & (cnt_q == CONV_LAST);

  // Repeat is sampled at the last tick: a new conversion follows with no gap
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q    <= 4'h0;
      busy_q   <= 1'b0;
      sample_q <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      done_q   <= last_tick & ~abort;
      sample_q <= ~abort & ((~busy_q & start) | (last_tick & repeat_conv));
      if (abort) begin
        busy_q <= 1'b0;
        cnt_q  <= 4'h0;
      end else if (!busy_q) begin
        busy_q <= start;
        cnt_q  <= 4'h0;
      end else if (last_tick) begin
        busy_q <= repeat_conv;
        cnt_q  <= 4'h0;
      end else if (tick) begin
        cnt_q  <= cnt_q + 4'h1;
      end
    end
  end

endmodule : adc_conversion_timer

// file: core/adc_sequencer_registers.sv
// Control and result registers with conversion sequencing for the 10-bit converter
//
// Summary of operation
// - Power-down bit set holds converter powered down
// - Mode 00: one conversion, threshold interrupt, stop
// - Mode 01: convert forever, interrupt on threshold
// - Mode 10: stop and clear run on threshold
// - Mode 11: system reset instead of interrupt
// - Reference select: supply or internal 1.25 V
// - Software sets run bit to begin converting
// - Single mode clears run bit when done
// - Cleared run ends after current conversion
// - Input select routes one of three pins
// - Select 11: pin zero, pin one reference
// - Low result byte read-only, resets zero
// - High bits latched on low byte read
// - Upper eight result bits compared, greater-equal
// - Eleven converter clocks per conversion
// - Main clock divided by sixteen times step
// - Results survive threshold-generated system reset
`timescale 1ns/1ps
module adc_sequencer_registers
  import adc_seq_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // System reset from the chip, keeps the results
  input  wire logic       system_reset_in,
  // Special-function register bus
  input  wire sfr_req_t   sfr_req,
  output logic [7:0]      sfr_rdata_q,
  output logic            sfr_hit_q,
  // Settings held in other registers
  input  wire logic [7:0] threshold_level,
  input  wire logic [5:0] clock_divider_select,
  input  wire logic       slow_clock_mode,
  input  wire logic       slow_clock,
  // Analog converter
  output analog_ctl_t     analog_q,
  input  wire logic [9:0] conversion_result,
  // Threshold events
  output logic            threshold_irq_q,
  output logic            threshold_reset_q
);

  // Sequencer: idle, converting, one cycle of threshold evaluation
  typedef enum {
    ST_IDLE,
    ST_CONVERT,
    ST_EVALUATE
  } seq_state_t;

  // Threshold compares only the upper eight bits of the sample
  function automatic logic threshold_met(input logic [9:0] res, input logic [7:0] thr);
    threshold_met = (res[9:2] >= thr);
  endfunction : threshold_met

  function automatic logic is_multi(input conv_mode_t m);
    is_multi = (m != MODE_SINGLE);
  endfunction : is_multi

  // Registers
  control_t   ctrl_q;
  control_t   ctrl_d;
  logic [9:0] result_q;
  logic [1:0] high_q;
  seq_state_t state_q;
  seq_state_t state_d;

  // Timer and divider wires
  logic conv_tick;
  logic conv_busy;
  logic conv_sample;
  logic conv_done;

  // Bus decode
  logic     sel_ctrl;
  logic     sel_low;
  logic     sel_high;
  logic     wr_ctrl;
  logic     rd_low;
  logic     any_sel;
  control_t wr_val;
  logic [7:0] rd_mux;

  assign sel_ctrl = (sfr_req.addr == ADDR_CONTROL);
  assign sel_low  = (sfr_req.addr == ADDR_RESULT_LOW);
  assign sel_high = (sfr_req.addr == ADDR_RESULT_HIGH);
  assign any_sel  = sel_ctrl | sel_low | sel_high;
  assign wr_ctrl  = sfr_req.wr & sel_ctrl;
  assign rd_low   = sfr_req.rd & sel_low;
  assign wr_val   = control_t'(sfr_req.wdata);

  // Field views for reads; reserved control bit and unused high bits read as zero
  logic [7:0] ctrl_rd;
  logic [7:0] high_rd;

  assign ctrl_rd = {ctrl_q[7], 1'b0, ctrl_q[5:0]};
  assign high_rd = {6'h00, high_q};

  // Read data select
  assign rd_mux = sel_ctrl ? ctrl_rd :
                  sel_low  ? result_q[7:0] :
                  sel_high ? high_rd :
                             READ_ZERO;

  // Sequencing conditions
  logic powered;
  logic single_mode;
  logic thr_hit;
  logic start_conv;
  logic repeat_conv;
  logic abort_conv;
  logic hw_clear_run;
  logic stop_on_hit;
  logic eval_now;

  // Power, mode and evaluate decodes
  assign powered     = ~ctrl_q.converter_powerdown;
  assign single_mode = ~is_multi(ctrl_q.conversion_mode_select);
  assign eval_now    = (state_q == ST_EVALUATE);
  // Evaluated from the stored result, one cycle after it is written
  assign thr_hit     = eval_now & threshold_met(result_q, threshold_level);
  assign stop_on_hit = thr_hit & (ctrl_q.conversion_mode_select == MODE_STOPPING);
  // Start only from idle so a finished single conversion does not rerun
  assign start_conv  = powered & ctrl_q.conversion_run & (state_q == ST_IDLE);
  // Run bit is looked at only at the end of a conversion
  assign repeat_conv = powered & ctrl_q.conversion_run & ~single_mode;
  // The conversion begun just before a stopping hit is thrown away
  assign abort_conv  = ~powered | system_reset_in | stop_on_hit;
  // Single mode ends at done; multi modes end on a cleared run or a stopping hit
  assign hw_clear_run = (conv_done & single_mode) | stop_on_hit;

  // Control register next value; a software write of run wins over the clear
  // System reset is applied last, so it beats a same-cycle write
  always_comb begin
    ctrl_d = ctrl_q;
    if (hw_clear_run) begin
      ctrl_d.conversion_run = 1'b0;
    end
    if (wr_ctrl) begin
      ctrl_d          = wr_val;
      ctrl_d.reserved = 1'b0;
    end
    if (system_reset_in) begin
      ctrl_d = control_t'(CONTROL_RESET);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= control_t'(CONTROL_RESET);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Sequencer state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_conv) begin
          state_d = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (conv_done) begin
          state_d = ST_EVALUATE;
        end else if (!conv_busy && !conv_sample) begin
          state_d = ST_IDLE;
        end
      end
      ST_EVALUATE: begin
        state_d = (conv_busy && !stop_on_hit) ? ST_CONVERT : ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Evaluate always runs out so a stopping hit still gets its action
    if (abort_conv && !eval_now) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Store on done; a low-byte read snapshots the top bits for the later high read
  logic store_result;
  logic latch_high;

  assign store_result = conv_done;
  assign latch_high   = rd_low;

  // Results clear only on power-up reset, never on the system reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      result_q <= RESULT_RESET;
      high_q   <= HIGH_RESET;
    end else begin
      if (store_result) begin
        result_q <= conversion_result;
      end
      if (latch_high) begin
        high_q <= result_q[9:8];
      end
    end
  end

  // Idle and unmapped cycles return zero so no stale byte stays on the bus
  logic [7:0] rdata_d;
  logic       hit_d;

  assign rdata_d = sfr_req.rd ? rd_mux : READ_ZERO;
  assign hit_d   = sfr_req.rd & any_sel;

  // Bus read data, registered one cycle after the read strobe
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata_q <= READ_ZERO;
      sfr_hit_q   <= 1'b0;
    end else begin
      sfr_rdata_q <= rdata_d;
      sfr_hit_q   <= hit_d;
    end
  end

  // Threshold actions: interrupt in three modes, system reset in the fourth
  logic reset_mode;
  logic irq_d;
  logic sys_reset_d;

  assign reset_mode  = (ctrl_q.conversion_mode_select == MODE_RESET_GEN);
  // Mode 11 keeps converting after a hit; the chip reset that follows stops it
  assign irq_d       = thr_hit & ~reset_mode;
  assign sys_reset_d = thr_hit & reset_mode;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      threshold_irq_q   <= 1'b0;
      threshold_reset_q <= 1'b0;
    end else begin
      threshold_irq_q   <= irq_d;
      threshold_reset_q <= sys_reset_d;
    end
  end

  // Analog controls; the external reference overrides the reference bit
  logic        ext_ref_sel;
  analog_ctl_t analog_d;

  assign ext_ref_sel = (ctrl_q.input_channel_select == CHAN_ZERO_EXT_REF);
  // Start is masked while powered down, so a start racing a power-down write is dropped
  assign analog_d = '{powerdown:    ctrl_q.converter_powerdown,
                      internal_ref: ctrl_q.reference_select & ~ext_ref_sel,
                      external_ref: ext_ref_sel,
                      channel:      ctrl_q.input_channel_select,
                      sample_start: conv_sample & ~ctrl_q.converter_powerdown,
                      clk_en:       conv_tick};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      analog_q <= '{powerdown: 1'b1, internal_ref: 1'b0, external_ref: 1'b0,
                    channel: CHAN_INPUT_ZERO, sample_start: 1'b0, clk_en: 1'b0};
    end else begin
      analog_q <= analog_d;
    end
  end

  // Power-up settling is left to software; the logic starts at once
  // Converter clock runs only while powered up
  adc_clock_divider u_divider (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .enable    (powered),
    .div_sel   (clock_divider_select),
    .slow_mode (slow_clock_mode),
    .slow_clk  (slow_clock),
    .tick_q    (conv_tick)
  );

  // Eleven-tick conversion counter
  adc_conversion_timer u_timer (
    .ref_clk     (ref_clk),
    .nrst        (nrst),
    .tick        (conv_tick),
    .start       (start_conv),
    .repeat_conv (repeat_conv),
    .abort       (abort_conv),
    .busy_q      (conv_busy),
    .sample_q    (conv_sample),
    .done_q      (conv_done)
  );

endmodule : adc_sequencer_registers

// file: test/adc_seq_sva.sv
// Port-level assertions for the converter sequencer
`timescale 1ns/1ps
module adc_seq_sva
  import adc_seq_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // Register bus
  input wire sfr_req_t    sfr_req,
  input wire logic [7:0]  sfr_rdata_q,
  input wire logic        sfr_hit_q,
  // Settings and converter
  input wire logic [7:0]  threshold_level,
  input wire logic [5:0]  clock_divider_select,
  input wire logic        slow_clock_mode,
  input wire analog_ctl_t analog_q,
  input wire logic [9:0]  conversion_result,
  // Events
  input wire logic        threshold_irq_q,
  input wire logic        threshold_reset_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Mapped read decode
  wire logic map_rd = sfr_req.rd && (sfr_req.addr inside
    {ADDR_CONTROL, ADDR_RESULT_LOW, ADDR_RESULT_HIGH});
  wire logic is95   = sfr_req.addr == ADDR_RESULT_HIGH;

  // Cycles since last converter tick, saturating so reset start is large
  logic [10:0] gap_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) gap_q <= 11'h7FF;
    else if (analog_q.clk_en) gap_q <= 11'h001;
    else if (gap_q != 11'h7FF) gap_q <= gap_q + 11'h001;
  end

  a_hit_mapped: assert property (map_rd |=> sfr_hit_q)
    else $error("mapped read without hit");
  a_idle_quiet: assert property (!map_rd |=> !sfr_hit_q && sfr_rdata_q == READ_ZERO)
    else $error("read data outside a mapped read");
  a_high_zeros: assert property (sfr_req.rd && is95 |=> sfr_rdata_q[7:2] == 6'h00)
    else $error("high bits register upper bits not zero");
  a_bit6_zero: assert property (sfr_req.rd && sfr_req.addr == ADDR_CONTROL |=> !sfr_rdata_q[6])
    else $error("reserved control bit reads one");
  a_pd_quiet: assert property (analog_q.powerdown |-> !analog_q.sample_start)
    else $error("conversion started while powered down");
  a_ref_mux: assert property (analog_q.external_ref == (analog_q.channel == CHAN_ZERO_EXT_REF)
    && !(analog_q.internal_ref && analog_q.external_ref))
    else $error("reference selection inconsistent");
  a_irq_level: assert property (threshold_irq_q |->
    $past(conversion_result[9:2], 2) >= $past(threshold_level, 2))
    else $error("interrupt below threshold");
  a_rst_level: assert property (threshold_reset_q |->
    $past(conversion_result[9:2], 2) >= $past(threshold_level, 2))
    else $error("system reset below threshold");
  a_evt_excl: assert property (!(threshold_irq_q && threshold_reset_q))
    else $error("interrupt and reset together");
  a_start_pulse: assert property (analog_q.sample_start |=> !analog_q.sample_start)
    else $error("start pulse longer than one cycle");
  a_tick_gap: assert property (analog_q.clk_en && !slow_clock_mode |->
    int'(gap_q) >= 16 * (int'(clock_divider_select) + 1))
    else $error("converter tick too early");

  // Main scenarios
  c_irq: cover property (threshold_irq_q);
  c_rst: cover property (threshold_reset_q);
  c_hit: cover property (sfr_hit_q);
  c_slow: cover property (slow_clock_mode && threshold_irq_q);
endmodule : adc_seq_sva

bind adc_sequencer_registers adc_seq_sva chk (.ref_clk, .nrst, .sfr_req, .sfr_rdata_q,
  .sfr_hit_q, .threshold_level, .clock_divider_select, .slow_clock_mode, .analog_q,
  .conversion_result, .threshold_irq_q, .threshold_reset_q);

// file: test/adc_analog_model.sv
// Behavioural analog converter, one sample held per conversion
`timescale 1ns/1ps
module adc_analog_model
  import adc_seq_pkg::*;
(
  // Clock
  input  wire logic        ref_clk,
  // Controls and level to convert
  input  wire analog_ctl_t ctl,
  input  wire logic [9:0]  level,
  // Converted value
  output logic [9:0]       result
);
  // Powered down output toggles so a stale value is never trusted
  initial result = 10'h000;
  always @(posedge ref_clk) begin
    if (ctl.powerdown) result <= ~result;
    else if (ctl.sample_start) result <= level;
  end
endmodule : adc_analog_model

// file: test/tb_adc_sequencer_registers.sv
// Self-checking bench for the converter sequencer registers
`timescale 1ns/1ps
module tb_adc_sequencer_registers;
  import adc_seq_pkg::*;
  logic        ref_clk, nrst, sys_rst, hit, irq, rst_evt, rd_d, slow_mode, slow_clk;
  sfr_req_t    req;
  logic [7:0]  rdata, thr;
  logic [5:0]  div;
  logic [9:0]  level, result, lvl;
  analog_ctl_t ana;
  logic [8:0]  rq[$];
  logic [1:0]  eq[$];
  int          error_cnt, checks_done, n;

  adc_sequencer_registers dut (.ref_clk(ref_clk), .nrst(nrst), .system_reset_in(sys_rst),
    .sfr_req(req), .sfr_rdata_q(rdata), .sfr_hit_q(hit), .threshold_level(thr),
    .clock_divider_select(div), .slow_clock_mode(slow_mode), .slow_clock(slow_clk),
    .analog_q(ana), .conversion_result(result), .threshold_irq_q(irq),
    .threshold_reset_q(rst_evt));
  adc_analog_model conv (.ref_clk(ref_clk), .ctl(ana), .level(level), .result(result));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Slow clock path, scaled down to keep runs short; changes just after an edge
  localparam int SLOW_HALF = 4;
  initial begin
    slow_clk = 1'b0;
    forever begin
      repeat (SLOW_HALF) @(posedge ref_clk);
      #1 slow_clk = ~slow_clk;
    end
  end

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic tally_and_finish();
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // One bus cycle; a read notes its expected {hit, data}
  task automatic bus(input logic w, input logic [7:0] a, input logic [8:0] x);
    if (!w) rq.push_back(x);
    @(posedge ref_clk);
    #1 req = '{addr: a, wdata: x[7:0], wr: w, rd: !w};
    @(posedge ref_clk);
    #1 req = '0;
  endtask : bus

  // Bounded wait for a threshold event, returns cycles waited
  task automatic wait_evt(output int k);
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (!(irq || rst_evt) && k < 1000);
    cmp("event wait", 16'h1, 16'(k < 1000));
  endtask : wait_evt

  // Answers show the cycle after the read; events pop the oldest note
  always @(posedge ref_clk) rd_d <= req.rd;
  always @(negedge ref_clk) begin
    if (rd_d && rq.size() == 0) cmp("read note", 16'h0, 16'h1);
    else if (rd_d) cmp("read", 16'(rq.pop_front()), {7'h00, hit, rdata});
    if ((irq || rst_evt) && eq.size() == 0) cmp("event note", 16'h0, 16'h1);
    else if (irq || rst_evt) cmp("event", 16'(eq.pop_front()), {rst_evt, irq});
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    cmp("watchdog", 16'h0, 16'h1);
    tally_and_finish();
  end

  initial begin
    req = '0; nrst = 1'b0; sys_rst = 1'b0; thr = 8'h00; div = 6'h00; level = 10'h000;
    slow_mode = 1'b0;
    void'($urandom(32353));
    repeat (5) @(posedge ref_clk);
    #1 nrst = 1'b1;
    // Reset values, unmapped address, read-only result
    bus(0, ADDR_CONTROL, {1'b1, CONTROL_RESET});
    bus(0, ADDR_RESULT_LOW, 9'h100);
    bus(0, ADDR_RESULT_HIGH, 9'h100);
    bus(0, 8'h96, 9'h000);
    bus(1, ADDR_RESULT_LOW, 9'h055);
    bus(0, ADDR_RESULT_LOW, 9'h100);
    bus(1, ADDR_CONTROL, 9'h0C3);
    bus(0, ADDR_CONTROL, 9'h183);
    // Every input selection with internal reference asked for
    for (int c = 0; c < 4; c++) begin
      bus(1, ADDR_CONTROL, 9'(8'h88 | c));
      repeat (2) @(posedge ref_clk);
      #1 cmp("channel", 16'(c), 16'(ana.channel));
      cmp("refs", (c == 3) ? 16'h1 : 16'h2, {ana.internal_ref, ana.external_ref});
      cmp("powerdown", 16'h1, 16'(ana.powerdown));
    end
    // Single conversion at the exact threshold, then latch order
    lvl = 10'($urandom_range(10'h3FB));
    level = lvl;
    thr = lvl[9:2];
    eq.push_back(2'b01);
    bus(1, ADDR_CONTROL, 9'h004);
    wait_evt(n);
    repeat (4) @(posedge ref_clk);
    bus(0, ADDR_CONTROL, 9'h100);
    bus(0, ADDR_RESULT_HIGH, 9'h100);
    bus(0, ADDR_RESULT_LOW, {1'b1, lvl[7:0]});
    bus(0, ADDR_RESULT_HIGH, {7'h40, lvl[9:8]});
    // One below threshold: no event
    thr = lvl[9:2] + 8'h01;
    bus(1, ADDR_CONTROL, 9'h004);
    repeat (250) @(posedge ref_clk);
    bus(0, ADDR_CONTROL, 9'h100);
    // Continuous mode, period and stop after the running conversion
    thr = 8'h00;
    bus(1, ADDR_CONTROL, 9'h014);
    for (int k = 0; k < 3; k++) begin
      eq.push_back(2'b01);
      wait_evt(n);
      if (k > 0) cmp("period", 16'(CONV_TICKS * DIV_STEP), 16'(n));
    end
    eq.push_back(2'b01);
    bus(1, ADDR_CONTROL, 9'h010);
    wait_evt(n);
    repeat (400) @(posedge ref_clk);
    // Stopping mode clears run on the first hit, slower divider
    #1 div = 6'h01;
    level = 10'($urandom_range(10'h3FF));
    eq.push_back(2'b01);
    bus(1, ADDR_CONTROL, 9'h024);
    wait_evt(n);
    repeat (400) @(posedge ref_clk);
    bus(0, ADDR_CONTROL, 9'h120);
    // Reset-generating mode; results survive the system reset
    lvl = 10'($urandom_range(10'h3FF));
    level = lvl;
    eq.push_back(2'b10);
    bus(1, ADDR_CONTROL, 9'h034);
    wait_evt(n);
    @(posedge ref_clk);
    #1 sys_rst = 1'b1;
    @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    bus(0, ADDR_CONTROL, {1'b1, CONTROL_RESET});
    bus(0, ADDR_RESULT_LOW, {1'b1, lvl[7:0]});
    bus(0, ADDR_RESULT_HIGH, {7'h40, lvl[9:8]});
    // Run requested while powered down: nothing converts
    bus(1, ADDR_CONTROL, 9'h094);
    repeat (400) @(posedge ref_clk);
    #1 cmp("powerdown", 16'h1, 16'(ana.powerdown));
    // Slow clock path: one converter tick per slow rising edge
    slow_mode = 1'b1;
    eq.push_back(2'b01);
    bus(1, ADDR_CONTROL, 9'h014);
    wait_evt(n);
    eq.push_back(2'b01);
    wait_evt(n);
    cmp("slow period", 16'(CONV_TICKS * 2 * SLOW_HALF), 16'(n));
    bus(1, ADDR_CONTROL, 9'h090);
    repeat (200) @(posedge ref_clk);
    cmp("pending events", 16'h0, 16'(eq.size()));
    tally_and_finish();
  end
endmodule : tb_adc_sequencer_registers
